// file: src/fxrpcs_map.svh
// Constant map for the 100 Mb/s receive decoder
`ifndef FXRPCS_MAP_SVH
`define FXRPCS_MAP_SVH
// ==========================================================
// Code-groups
`define FXR_CG_IDLE 5'h1f
`define FXR_CG_J 5'h18
`define FXR_CG_K 5'h11
`define FXR_CG_T 5'h0d
`define FXR_CG_R 5'h07
`define FXR_CG_H 5'h04
// ==========================================================
// Nibbles
`define FXR_NIB_PRE 4'h5
`define FXR_NIB_BADSSD 4'he
`define FXR_NIB_ZERO 4'h0
// ==========================================================
// Descrambler sync
`define FXR_LOCK_IDLES 4'hc
`define FXR_IDLE_BITS 6'h3a
`define FXR_HOLD_US 722
`define FXR_LINK_US 395
`define FXR_CLK_MHZ 200
// 11-bit scrambler taps x^11 + x^9 + 1
`define FXR_LFSR_TAP_A 10
`define FXR_LFSR_TAP_B 8
`define FXR_SYM_LAST 3'h4
// Bit index within a group three bits after the first zero
`define FXR_BAD_PHASE 3'h2
`endif

// file: src/fxrpcs_pkg.sv
// Types of the 100 Mb/s receive decoder
package fxrpcs_pkg;
  // ==========================================================
  // Receive state; the pre->data and idle->bad steps change both code bits
  typedef enum logic [1:0] {
    FXR_ST_IDLE = 2'b00,
    FXR_ST_DATA = 2'b01,
    FXR_ST_BAD = 2'b11,
    FXR_ST_PRE = 2'b10
  } fxr_state_t;
  // Nibble carried to the MAC side
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nib;
  } fxr_mii_t;
endpackage

// file: src/fxrpcs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fxrpcs_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic do_wr;
  logic do_rd;
  // Honest full and empty from occupancy
  assign wr_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_ff != '0);
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem[rp_ff];
  // Storage, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wp_ff] <= wr_data_in;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (do_rd) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // fxrpcs_fifo

// file: src/fxrpcs_top.sv
// Receive PCS: MLT-3 to NRZ, descrambler, aligner, 4B/5B decoder, link monitor
//
// Overview of operation
// R01: Signal detect ignores link pulses, needs energy
// R02: Three-level symbols become NRZI bits
// R03: NRZI transition means one, gives NRZ
// R04: Bits grouped into 5-bit symbols
// R05: Descrambler XORs with local scrambler sequence
// R06: Lock after 12 consecutive descrambled idles
// R07: Lock starts 722 us hold countdown
// R08: 58 idle bits restart hold countdown
// R09: Hold expiry drops lock, reacquires sync
// R10: Aligner input descrambled or bypassed NRZ
// R11: J/K pair fixes symbol boundary
// R12: Aligned code-groups decoded by lookup table
// R13: J/K after idles gives preamble nibbles
// R14: Decoding stops at T/R or two idles
// R15: Link up after 395 us signal detect
// R16: Non-idle after idles without J/K flagged; a J without K is not flagged
// R17: Bad delimiter drives error and 1110
// R18: Each bad delimiter bumps counter once
// R19: Two idles clear error and carrier
// R20: Standard 4B/5B code table used
// R21: Control codes inside data are errors; a T or a lone idle in data is dropped without error
`timescale 1ns/1ps
`include "fxrpcs_map.svh"
module fxrpcs_top #(
  parameter int HOLD_CYC = (`FXR_HOLD_US * `FXR_CLK_MHZ),
  parameter int LINK_CYC = (`FXR_LINK_US * `FXR_CLK_MHZ),
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Line side: one symbol per clock, sign and magnitude of MLT-3 level
  input wire logic SYM_VALID_IN,
  input wire logic [1:0] SYM_LEVEL_IN,
  input wire logic ENERGY_IN,
  input wire logic PULSE_ONLY_IN,
  // Control
  input wire logic DESCR_BYPASS_IN,
  // MAC nibble side
  output logic RX_DV_OUT,
  output logic RX_ER_OUT,
  output logic [3:0] RXD_OUT,
  output logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  output logic CRS_OUT,
  // Status
  output logic SIG_DET_OUT,
  output logic LINK_UP_OUT,
  output logic LOCKED_OUT,
  output logic [CNT_W-1:0] FALSE_CARRIER_EVENT_COUNTER_OUT,
  output logic OVERRUN_OUT
);
  // ==========================================================
  // Functions
  // 4B/5B decode; bit 4 of result flags a non-data code
  function automatic logic [4:0] dec5b(input logic [4:0] cg);
    case (cg) // R20
      5'h1e: dec5b = 5'h00;
      5'h09: dec5b = 5'h01;
      5'h14: dec5b = 5'h02;
      5'h15: dec5b = 5'h03;
      5'h0a: dec5b = 5'h04;
      5'h0b: dec5b = 5'h05;
      5'h0e: dec5b = 5'h06;
      5'h0f: dec5b = 5'h07;
      5'h12: dec5b = 5'h08;
      5'h13: dec5b = 5'h09;
      5'h16: dec5b = 5'h0a;
      5'h17: dec5b = 5'h0b;
      5'h1a: dec5b = 5'h0c;
      5'h1b: dec5b = 5'h0d;
      5'h1c: dec5b = 5'h0e;
      5'h1d: dec5b = 5'h0f;
      default: dec5b = 5'h1e;
    endcase
  endfunction
  function automatic logic is_idle(input logic [4:0] cg);
    is_idle = (cg == `FXR_CG_IDLE);
  endfunction
  // ==========================================================
  // Line conversion
  logic prev_lvl_ff;
  logic nrzi_bit;
  logic nrz_bit;
  logic bit_ok;
  logic link_up_ff;
  logic lock_ff;
  // Any nonzero MLT-3 level is a one in NRZI
  assign nrzi_bit = (SYM_LEVEL_IN != 2'b00); // R02
  assign nrz_bit = nrzi_bit ^ prev_lvl_ff; // R03
  // Receive coding held off until link-up
  assign bit_ok = SYM_VALID_IN && link_up_ff; // R15
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prev_lvl_ff <= 1'b0;
    end else if (SYM_VALID_IN) begin
      prev_lvl_ff <= nrzi_bit;
    end
  end
  // ==========================================================
  // Signal detect and link monitor
  logic [$clog2(LINK_CYC+1)-1:0] link_cnt_ff;
  // Link pulses alone never count as signal
  assign SIG_DET_OUT = ENERGY_IN && !PULSE_ONLY_IN; // R01
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      link_cnt_ff <= '0;
      link_up_ff <= 1'b0;
    end else if (!SIG_DET_OUT) begin
      link_cnt_ff <= '0;
      link_up_ff <= 1'b0;
    end else if (link_cnt_ff == ($bits(link_cnt_ff))'(LINK_CYC - 1)) begin
      link_up_ff <= 1'b1; // R15
    end else begin
      link_cnt_ff <= link_cnt_ff + 1'b1;
    end
  end
  assign LINK_UP_OUT = link_up_ff;
  // ==========================================================
  // Descrambler: local LFSR runs free; while unlocked it is
  // loaded from the scrambled stream assuming idle (all ones)
  logic [10:0] lfsr_ff;
  logic key;
  logic dbit;
  logic abit;
  logic [3:0] lock_idles_ff;
  logic [5:0] ones_ff;
  logic [$clog2(HOLD_CYC+1)-1:0] hold_ff;
  logic [2:0] sym_cnt_ff;
  assign key = lfsr_ff[`FXR_LFSR_TAP_A] ^ lfsr_ff[`FXR_LFSR_TAP_B];
  assign dbit = nrz_bit ^ key; // R05
  assign abit = DESCR_BYPASS_IN ? nrz_bit : dbit; // R10
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      lfsr_ff <= '0;
    end else if (bit_ok) begin
      // Unlocked: scrambled idle equals key inverted, so seed from line
      lfsr_ff <= {lfsr_ff[9:0], lock_ff ? key : ~nrz_bit};
    end
  end
  // Run of consecutive descrambled ones, also the line-state monitor
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ones_ff <= '0;
      sym_cnt_ff <= '0;
      lock_idles_ff <= '0;
    end else if (!link_up_ff) begin
      ones_ff <= '0;
      sym_cnt_ff <= '0;
      lock_idles_ff <= '0;
    end else if (bit_ok) begin
      ones_ff <= !dbit ? '0 : (ones_ff == `FXR_IDLE_BITS) ? ones_ff : ones_ff + 1'b1;
      sym_cnt_ff <= (sym_cnt_ff == `FXR_SYM_LAST) ? '0 : sym_cnt_ff + 1'b1;
      // Every fifth ones-run bit ends an idle; unaligned is fine for idles
      if (!dbit) begin
        lock_idles_ff <= '0;
      end else if (sym_cnt_ff == `FXR_SYM_LAST && lock_idles_ff != `FXR_LOCK_IDLES) begin
        lock_idles_ff <= lock_idles_ff + 1'b1; // R06
      end
    end
  end
  // Lock and hold timer
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      lock_ff <= 1'b0;
      hold_ff <= '0;
    end else if (!link_up_ff) begin
      lock_ff <= 1'b0;
      hold_ff <= '0;
    end else if (!lock_ff) begin
      if (lock_idles_ff == `FXR_LOCK_IDLES) begin
        lock_ff <= 1'b1; // R06
        hold_ff <= ($bits(hold_ff))'(HOLD_CYC); // R07
      end
    end else if (ones_ff == `FXR_IDLE_BITS) begin
      hold_ff <= ($bits(hold_ff))'(HOLD_CYC); // R08
    end else if (hold_ff == '0) begin
      lock_ff <= 1'b0; // R09
    end else begin
      hold_ff <= hold_ff - 1'b1;
    end
  end
  assign LOCKED_OUT = lock_ff;
  // ==========================================================
  // Aligner: 10-bit window, J/K fixes the boundary
  logic [9:0] win_ff;
  logic [2:0] phase_ff;
  logic aligned_ff;
  logic [9:0] win_nxt;
  logic cg_stb;
  logic [4:0] cg;
  logic [4:0] prev_cg_ff;
  logic stream_ok;
  logic bad_evt;
  logic end_evt;
  assign stream_ok = bit_ok && (lock_ff || DESCR_BYPASS_IN);
  assign win_nxt = {win_ff[8:0], abit}; // R04
  assign cg = win_nxt[4:0];
  assign cg_stb = stream_ok && aligned_ff && (phase_ff == `FXR_SYM_LAST);
  fxrpcs_pkg::fxr_state_t st_ff;
  // First zero after idles not followed by J's 00; a J without K is not caught
  assign bad_evt = stream_ok && !aligned_ff && st_ff == fxrpcs_pkg::FXR_ST_IDLE && (&win_nxt[9:3]) &&
                   !win_nxt[2] && (|win_nxt[1:0]); // R16
  assign end_evt = cg_stb && ((st_ff == fxrpcs_pkg::FXR_ST_DATA && cg == `FXR_CG_R && prev_cg_ff == `FXR_CG_T) ||
                   (st_ff != fxrpcs_pkg::FXR_ST_IDLE && is_idle(cg) && is_idle(prev_cg_ff))); // R14 R19
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      win_ff <= '0;
      phase_ff <= '0;
      aligned_ff <= 1'b0;
    end else if (!stream_ok) begin
      aligned_ff <= 1'b0;
      phase_ff <= '0;
    end else begin
      win_ff <= win_nxt;
      if (!aligned_ff) begin
        if (win_nxt == {`FXR_CG_J, `FXR_CG_K}) begin
          aligned_ff <= 1'b1; // R11
          phase_ff <= '0;
        end else if (bad_evt) begin
          aligned_ff <= 1'b1;
          phase_ff <= `FXR_BAD_PHASE;
        end
      end else begin
        phase_ff <= (phase_ff == `FXR_SYM_LAST) ? '0 : phase_ff + 1'b1;
        if (end_evt) begin
          aligned_ff <= 1'b0;
        end
      end
    end
  end
  // ==========================================================
  // Decoder state machine
  logic [4:0] dec;
  fxrpcs_pkg::fxr_mii_t out_w;
  logic out_stb;
  logic [CNT_W-1:0] fc_cnt_ff;
  logic in_ready;
  assign dec = dec5b(cg); // R12
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_ff <= fxrpcs_pkg::FXR_ST_IDLE;
      prev_cg_ff <= `FXR_CG_IDLE;
    end else if (!stream_ok) begin
      st_ff <= fxrpcs_pkg::FXR_ST_IDLE;
      prev_cg_ff <= `FXR_CG_IDLE;
    end else if (bad_evt) begin
      st_ff <= fxrpcs_pkg::FXR_ST_BAD; // R16
      prev_cg_ff <= `FXR_CG_K;
    end else if (aligned_ff && phase_ff == '0 && st_ff == fxrpcs_pkg::FXR_ST_IDLE) begin
      st_ff <= fxrpcs_pkg::FXR_ST_PRE; // R13
    end else if (st_ff == fxrpcs_pkg::FXR_ST_PRE) begin
      st_ff <= fxrpcs_pkg::FXR_ST_DATA;
      prev_cg_ff <= `FXR_CG_K;
    end else if (cg_stb) begin
      prev_cg_ff <= cg;
      case (st_ff)
        fxrpcs_pkg::FXR_ST_DATA, fxrpcs_pkg::FXR_ST_BAD: st_ff <= end_evt ? fxrpcs_pkg::FXR_ST_IDLE : st_ff; // R14 R19
        default: st_ff <= fxrpcs_pkg::FXR_ST_IDLE;
      endcase
    end
  end
  // Output nibble per code-group
  always_comb begin
    out_w = '0;
    out_stb = 1'b0;
    if (bad_evt) begin
      out_stb = 1'b1;
      out_w = '{dv: 1'b0, er: 1'b1, nib: `FXR_NIB_BADSSD}; // R17
    end else if (stream_ok && (st_ff == fxrpcs_pkg::FXR_ST_PRE ||
                 (aligned_ff && phase_ff == '0 && st_ff == fxrpcs_pkg::FXR_ST_IDLE))) begin
      out_stb = 1'b1;
      out_w = '{dv: 1'b1, er: 1'b0, nib: `FXR_NIB_PRE}; // R13
    end else if (cg_stb) begin
      case (st_ff)
        fxrpcs_pkg::FXR_ST_DATA: begin
          out_stb = !(cg == `FXR_CG_T || (cg == `FXR_CG_R && prev_cg_ff == `FXR_CG_T) || is_idle(cg));
          out_w = '{dv: 1'b1, er: dec[4], nib: dec[3:0]}; // R21
        end
        fxrpcs_pkg::FXR_ST_BAD: begin
          out_stb = !is_idle(cg);
          out_w = '{dv: 1'b0, er: 1'b1, nib: `FXR_NIB_BADSSD}; // R17
        end
        default: out_stb = 1'b0;
      endcase
    end
  end
  // False carrier counter, one per event
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      fc_cnt_ff <= '0;
    end else if (bad_evt) begin
      fc_cnt_ff <= fc_cnt_ff + 1'b1; // R18
    end
  end
  assign FALSE_CARRIER_EVENT_COUNTER_OUT = fc_cnt_ff;
  // Carrier sense while a packet or bad delimiter is active
  logic crs_ff;
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      crs_ff <= 1'b0;
    end else begin
      crs_ff <= (st_ff != fxrpcs_pkg::FXR_ST_IDLE); // R19
    end
  end
  assign CRS_OUT = crs_ff;
  // Line cannot stall, so a full FIFO drops nibbles and flags overrun
  logic ovr_ff;
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ovr_ff <= 1'b0;
    end else if (out_stb && !in_ready) begin
      ovr_ff <= 1'b1;
    end
  end
  assign OVERRUN_OUT = ovr_ff;
  // ==========================================================
  // Nibble FIFO toward the MAC
  fxrpcs_pkg::fxr_mii_t fifo_q;
  fxrpcs_fifo #(.WIDTH($bits(fxrpcs_pkg::fxr_mii_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .wr_valid_in(out_stb),
    .wr_ready_out(in_ready),
    .wr_data_in(out_w),
    .rd_valid_out(RX_VALID_OUT),
    .rd_ready_in(RX_READY_IN),
    .rd_data_out(fifo_q)
  );
  assign RX_DV_OUT = RX_VALID_OUT && fifo_q.dv;
  assign RX_ER_OUT = RX_VALID_OUT && fifo_q.er; // R17
  assign RXD_OUT = RX_VALID_OUT ? fifo_q.nib : `FXR_NIB_ZERO;
endmodule // fxrpcs_top

// file: testbench/fxrpcs_top_assertions.sv
// Port-level checks of the receive decoder
`timescale 1ns/1ps
module fxrpcs_top_assertions #(
  parameter int HOLD_CYC = 200,
  parameter int LINK_CYC = 50,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Watched ports
  input wire logic ENERGY_IN,
  input wire logic PULSE_ONLY_IN,
  input wire logic RX_DV_OUT,
  input wire logic RX_ER_OUT,
  input wire logic [3:0] RXD_OUT,
  input wire logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  input wire logic CRS_OUT,
  input wire logic SIG_DET_OUT,
  input wire logic LINK_UP_OUT,
  input wire logic LOCKED_OUT,
  input wire logic [CNT_W-1:0] FALSE_CARRIER_EVENT_COUNTER_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  int det_cnt_ff;
  int lock_age_ff;
  // ==========================================================
  // Run lengths, saturated so a long run never wraps
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) det_cnt_ff <= 0;
    else if (!SIG_DET_OUT) det_cnt_ff <= 0;
    else if (det_cnt_ff < 1000000) det_cnt_ff <= det_cnt_ff + 1;
  end
  // Cycles spent locked since lock was last gained
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) lock_age_ff <= 0;
    else if (!LOCKED_OUT) lock_age_ff <= 0;
    else if (lock_age_ff < 1000000) lock_age_ff <= lock_age_ff + 1;
  end
  // ==========================================================
  // Properties
  sequence s_new_event;
    $changed(FALSE_CARRIER_EVENT_COUNTER_OUT);
  endsequence
  a_sigdet_pulse: assert property (PULSE_ONLY_IN |-> !SIG_DET_OUT)
    else $error("signal detect raised by link pulses");
  a_sigdet_level: assert property (SIG_DET_OUT == (ENERGY_IN && !PULSE_ONLY_IN))
    else $error("signal detect does not follow energy");
  a_link_after_det: assert property ($rose(LINK_UP_OUT) |-> det_cnt_ff >= LINK_CYC - 1)
    else $error("link up too early");
  a_link_gates: assert property (!LINK_UP_OUT [*3] |-> !LOCKED_OUT && !CRS_OUT)
    else $error("receive active without link");
  a_lock_hold: assert property ($fell(LOCKED_OUT) |-> lock_age_ff >= HOLD_CYC - 1)
    else $error("lock dropped before hold expiry");
  a_count_step: assert property ($changed(FALSE_CARRIER_EVENT_COUNTER_OUT) |->
    FALSE_CARRIER_EVENT_COUNTER_OUT == $past(FALSE_CARRIER_EVENT_COUNTER_OUT) + 1'b1)
    else $error("false carrier counter step not one");
  a_event_carrier: assert property (s_new_event |-> ##[0:3] CRS_OUT)
    else $error("bad delimiter without carrier");
  a_head_stands: assert property (RX_VALID_OUT && !RX_READY_IN |=>
    RX_VALID_OUT && $stable({RX_DV_OUT, RX_ER_OUT, RXD_OUT}))
    else $error("nibble changed before pop");
endmodule // fxrpcs_top_assertions

bind fxrpcs_top fxrpcs_top_assertions #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC), .CNT_W(CNT_W))
  fxrpcs_top_assertions_inst (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .ENERGY_IN(ENERGY_IN),
  .PULSE_ONLY_IN(PULSE_ONLY_IN), .RX_DV_OUT(RX_DV_OUT), .RX_ER_OUT(RX_ER_OUT), .RXD_OUT(RXD_OUT),
  .RX_VALID_OUT(RX_VALID_OUT), .RX_READY_IN(RX_READY_IN), .CRS_OUT(CRS_OUT), .SIG_DET_OUT(SIG_DET_OUT),
  .LINK_UP_OUT(LINK_UP_OUT), .LOCKED_OUT(LOCKED_OUT),
  .FALSE_CARRIER_EVENT_COUNTER_OUT(FALSE_CARRIER_EVENT_COUNTER_OUT));

// file: testbench/fxrpcs_mac_model.sv
// MAC-side model that pops nibbles promptly, slowly or not at all
`timescale 1ns/1ps
module fxrpcs_mac_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pacing
  input wire logic stall_in,
  input wire logic slow_in,
  // Nibble stream
  input wire logic valid_in,
  input wire fxrpcs_pkg::fxr_mii_t mii_in,
  output logic ready_out
);
  fxrpcs_pkg::fxr_mii_t got[$];
  logic phase_ff;
  // Slow pacing accepts on every other edge only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_ff <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      phase_ff <= !phase_ff;
      ready_out <= !stall_in && (!slow_in || phase_ff);
    end
  end
  // Keep every popped nibble for the bench to judge
  always @(posedge clk_in) begin
    if (valid_in && ready_out) got.push_back(mii_in);
  end
endmodule // fxrpcs_mac_model

// file: testbench/fxrpcs_top_tb.sv
// Self-checking bench of the receive decoder
`timescale 1ns/1ps
`include "fxrpcs_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module fxrpcs_top_tb;
  localparam int HOLD = 200;
  localparam int LINK = 50;
  localparam logic [4:0] DATA_CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sym_valid = 1'b0;
  logic [1:0] sym_level = 2'h0;
  logic energy = 1'b0;
  logic pulse_only = 1'b0;
  logic bypass = 1'b1;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic nrzi = 1'b0;
  logic pol = 1'b0;
  logic scr_on = 1'b0;
  logic [10:0] lfsr = 11'h5a3;
  logic rx_ready, rx_dv, rx_er, rx_valid, crs, sig_det, link_up, locked, overrun;
  logic [3:0] rxd;
  logic [15:0] fc_cnt;
  fxrpcs_pkg::fxr_mii_t m;
  int err_total = 0;
  int comparisons = 0;
  // ==========================================================
  // Clock, design and MAC side
  always #2.5 clk = !clk;
  fxrpcs_top #(.HOLD_CYC(HOLD), .LINK_CYC(LINK)) fxrpcs_top_inst (.REF_CLK_IN(clk), .RESET_IN(rst),
    .SYM_VALID_IN(sym_valid), .SYM_LEVEL_IN(sym_level), .ENERGY_IN(energy), .PULSE_ONLY_IN(pulse_only),
    .DESCR_BYPASS_IN(bypass), .RX_DV_OUT(rx_dv), .RX_ER_OUT(rx_er), .RXD_OUT(rxd), .RX_VALID_OUT(rx_valid),
    .RX_READY_IN(rx_ready), .CRS_OUT(crs), .SIG_DET_OUT(sig_det), .LINK_UP_OUT(link_up),
    .LOCKED_OUT(locked), .FALSE_CARRIER_EVENT_COUNTER_OUT(fc_cnt), .OVERRUN_OUT(overrun));
  fxrpcs_mac_model fxrpcs_mac_model_inst (.clk_in(clk), .rst_in(rst), .stall_in(stall), .slow_in(slow),
    .valid_in(rx_valid), .mii_in({rx_dv, rx_er, rxd}), .ready_out(rx_ready));
  // ==========================================================
  // Line drivers: scramble, NRZI, then MLT-3 level
  task automatic send_bit(input logic b);
    logic key;
    key = lfsr[10] ^ lfsr[8];
    if (scr_on) lfsr = {lfsr[9:0], key};
    @(negedge clk);
    if (scr_on ? (b ^ key) : b) begin
      nrzi = !nrzi;
      if (!nrzi) pol = !pol;
    end
    sym_level = nrzi ? {pol, 1'b1} : 2'h0;
    sym_valid = 1'b1;
  endtask
  task automatic send_cg(input logic [4:0] cg, input int n);
    repeat (n) for (int i = 4; i >= 0; i--) send_bit(cg[i]);
  endtask
  // Quiet line, bounded wait for n popped nibbles
  task automatic wait_got(input int n);
    @(negedge clk);
    sym_valid = 1'b0;
    for (int i = 0; i < 400 && fxrpcs_mac_model_inst.got.size() < n; i++) @(negedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_link();
    energy = 1'b1;
    pulse_only = 1'b1;
    repeat (2 * LINK) @(negedge clk);
    `CHK(sig_det, 1'b0)
    `CHK(link_up, 1'b0)
    pulse_only = 1'b0;
    repeat (LINK - 5) @(negedge clk);
    `CHK(link_up, 1'b0)
    repeat (10) @(negedge clk);
    `CHK(link_up, 1'b1)
  endtask
  task automatic t_packet();
    slow = 1'b1;
    send_cg(`FXR_CG_IDLE, 4);
    send_cg(`FXR_CG_J, 1);
    send_cg(`FXR_CG_K, 1);
    for (int i = 0; i < 16; i++) send_cg(DATA_CG[i], 1);
    send_cg(`FXR_CG_J, 1);
    send_cg(`FXR_CG_T, 1);
    send_cg(`FXR_CG_R, 1);
    send_cg(`FXR_CG_IDLE, 4);
    wait_got(19);
    `CHK(fxrpcs_mac_model_inst.got.size(), 19)
    for (int i = 0; i < 18; i++) begin
      m = fxrpcs_mac_model_inst.got.pop_front();
      `CHK(m, {2'b10, (i < 2) ? `FXR_NIB_PRE : 4'(i - 2)})
    end
    m = fxrpcs_mac_model_inst.got.pop_front();
    `CHK(m.er, 1'b1)
    slow = 1'b0;
  endtask
  task automatic t_bad();
    logic [15:0] c0;
    c0 = fc_cnt;
    send_cg(`FXR_CG_IDLE, 4);
    send_cg(DATA_CG[0], 2);
    send_cg(`FXR_CG_IDLE, 4);
    wait_got(2);
    for (int i = 0; i < 2; i++) begin
      m = fxrpcs_mac_model_inst.got.pop_front();
      `CHK({m.er, m.nib}, {1'b1, `FXR_NIB_BADSSD})
    end
    `CHK(fc_cnt, c0 + 16'h1)
    `CHK(crs, 1'b0)
    fxrpcs_mac_model_inst.got.delete();
  endtask
  task automatic t_lock();
    bypass = 1'b0;
    scr_on = 1'b1;
    send_cg(`FXR_CG_IDLE, 8);
    `CHK(locked, 1'b0)
    send_cg(`FXR_CG_IDLE, 12);
    `CHK(locked, 1'b1)
    send_cg(`FXR_CG_IDLE, 2 * HOLD / 5);
    `CHK(locked, 1'b1)
    send_cg(5'h00, 2 * HOLD / 5);
    `CHK(locked, 1'b0)
    send_cg(`FXR_CG_IDLE, 20);
    `CHK(locked, 1'b1)
    wait_got(0);
    scr_on = 1'b0;
    bypass = 1'b1;
    fxrpcs_mac_model_inst.got.delete();
  endtask
  task automatic t_overrun();
    stall = 1'b1;
    send_cg(`FXR_CG_IDLE, 4);
    send_cg(`FXR_CG_J, 1);
    send_cg(`FXR_CG_K, 1);
    for (int i = 0; i < 20; i++) send_cg(DATA_CG[i % 16], 1);
    send_cg(`FXR_CG_T, 1);
    send_cg(`FXR_CG_R, 1);
    send_cg(`FXR_CG_IDLE, 4);
    wait_got(0);
    `CHK({overrun, rx_valid}, 2'b11)
    stall = 1'b0;
    wait_got(16);
    repeat (20) @(negedge clk);
    `CHK(fxrpcs_mac_model_inst.got.size(), 16)
    `CHK(fxrpcs_mac_model_inst.got[0], {2'b10, `FXR_NIB_PRE})
    `CHK(rx_valid, 1'b0)
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_link();
    t_packet();
    t_bad();
    t_lock();
    t_overrun();
    give_verdict();
  end
  // Far beyond the few thousand cycles the scenarios need
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule // fxrpcs_top_tb
